/* bench/overcharge_seq_assertions.sv */
// port-level assertion checker for the overcharge sequencer
`timescale 1ns/100ps
`include "overcharge_map.svh"
module overcharge_seq_assertions (
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  ce_i,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire logic                  ddp_block_i,
    input wire overcharge_pkg::meas_t meas_i,
    input wire overcharge_pkg::cmd_t  cmd_o
);
    import overcharge_pkg::*;
    // one clock domain, so clock and reset are given once
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // bus answer comes exactly one cycle after a taken request
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
        |=> wb_ack_o) else $error("bus request not answered");
    ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without request");
    // read data is zero outside the ack cycle
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not idle");

    // command outputs of the sequencer
    float_pulse_a: assert property (
        cmd_o.float_req |=> !cmd_o.float_req)
        else $error("float request not a pulse");
    test_off_a: assert property (
        cmd_o.footer == `FOOT_TEST |-> cmd_o.off)
        else $error("test letter without off state");
    ddp_cancel_a: assert property (
        ddp_block_i && cmd_o.footer == `FOOT_TEST
        |-> ##[1:3] cmd_o.footer != `FOOT_TEST)
        else $error("blocked discharge did not cancel test");
    final_foot_a: assert property (
        cmd_o.ilimit_en |-> cmd_o.footer == `FOOT_FINAL)
        else $error("limited phase without its letter");
    trip_off_a: assert property (
        cmd_o.ilimit_en && meas_i.cell_mv >= `TRIP_MV |-> ##[1:3] cmd_o.off)
        else $error("overvoltage did not switch off");
    off_quiet_a: assert property (
        cmd_o.off [*3] |-> !cmd_o.ilimit_en && !cmd_o.cv_volt)
        else $error("cycle still active while off");
endmodule : overcharge_seq_assertions

bind overcharge_seq overcharge_seq_assertions overcharge_seq_assertions_i (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .ddp_block_i, .meas_i, .cmd_o
);

/* bench/overcharge_seq_tb.sv */
// self-checking bench for the overcharge sequencer
`timescale 1ns/100ps
`include "overcharge_map.svh"
module overcharge_seq_tb;
    import overcharge_pkg::*;
    localparam int SEC = 20; // short second keeps the run small
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        ce_i = 1'h1;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic        wb_we_i = 1'h0;
    logic        wb_cyc_i = 1'h0;
    logic        wb_stb_i = 1'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        confirm_btn_i = 1'h0;
    logic        ddp_block_i = 1'h0;
    logic        boost_done_i = 1'h0;
    logic        month_tick_i = 1'h0;
    meas_t       meas_i = '0;
    cmd_t        cmd_o;
    int          num_errors = 0;
    int          total_checks = 0;
    int          float_cnt = 0;
    logic [31:0] q;

    overcharge_seq #(.SEC_CYCLES(SEC)) overcharge_seq_i (
        .clk_i, .rst_i, .ce_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i(4'hF), .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
        .wb_ack_o, .confirm_btn_i, .ddp_block_i, .boost_done_i,
        .month_tick_i, .meas_i, .cmd_o
    );

    // 200 MHz clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // float requests are single pulses, so count them as they pass
    always @(posedge clk_i) begin
        if (cmd_o.float_req === 1'h1) float_cnt <= float_cnt + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one classic bus cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : wb
    task automatic rdm(input logic [7:0] adr, input logic [31:0] m,
                       input logic [31:0] exp);
        wb(1'h0, adr, 32'h0000_0000);
        check(q & m, exp);
    endtask : rdm
    // poll the phase field, a bounded number of reads per second
    task automatic wait_phase(input logic [1:0] ph, input int secs);
        int n;
        n = 0;
        do begin
            wb(1'h0, `ADR_STAT, 32'h0000_0000);
            n++;
        end while (q[1:0] !== ph && n < secs * 10);
        check(q[1:0], ph);
    endtask : wait_phase
    task automatic press(input int n);
        wb(1'h1, `ADR_TEST, 32'h0000_0001);
        confirm_btn_i <= 1'h1;
        repeat (n) @(posedge clk_i);
        confirm_btn_i <= 1'h0;
    endtask : press
    task automatic boost();
        boost_done_i <= 1'h1;
        @(posedge clk_i);
        boost_done_i <= 1'h0;
    endtask : boost
    task automatic tick();
        month_tick_i <= 1'h1;
        @(posedge clk_i);
        month_tick_i <= 1'h0;
    endtask : tick
    task automatic to_final();
        boost();
        wait_phase(2'h1, 2);
        check(cmd_o.boost_volt, 1'h1);
        wait_phase(2'h2, 4);
        check(cmd_o.cv_volt, 1'h1);
        wait_phase(2'h3, 56);
    endtask : to_final

    task automatic t_regs();
        rdm(`ADR_CTRL, 32'hFFFF_FFFF, `CTRL_RST);
        wb(1'h1, `ADR_CAP, 32'h0000_0064);
        rdm(`ADR_IREF, 32'hFFFF_FFFF, 32'h0000_07D0);
        wb(1'h1, `ADR_STAT, 32'hFFFF_FFFF);
        rdm(`ADR_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
        wb(1'h1, 8'h40, 32'hFFFF_FFFF);
        rdm(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        // other battery type, or a capacity below the minimum, must not arm the cycle
        wb(1'h1, `ADR_CTRL, 32'h0000_0033);
        rdm(`ADR_STAT, 32'h0000_0004, 32'h0000_0000);
        wb(1'h1, `ADR_CAP, 32'h0000_0031);
        wb(1'h1, `ADR_CTRL, 32'h0000_0023);
        rdm(`ADR_STAT, 32'h0000_0004, 32'h0000_0000);
        $display("registers test done");
    endtask : t_regs

    // start thresholds read as millivolts, then as percent
    task automatic t_thr();
        meas_i.bat_mv  <= 16'h000A;
        meas_i.soc_pct <= 7'h3C;
        wb(1'h1, `ADR_THR, 32'h0032_0014);
        rdm(`ADR_THR, 32'hFFFF_FFFF, 32'h0032_0014);
        check(cmd_o.boost_start, 1'h1);
        check(cmd_o.eq_start, 1'h1);
        // with the clock enable low the commands must hold still
        ce_i          <= 1'h0;
        meas_i.bat_mv <= 16'h0040;
        repeat (3) @(posedge clk_i);
        check(cmd_o.eq_start, 1'h1);
        ce_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        check(cmd_o.eq_start, 1'h0);
        // same low voltage, but the percent reading is above both
        meas_i.bat_mv <= 16'h000A;
        wb(1'h1, `ADR_CTRL, 32'h0000_0027);
        rdm(`ADR_CTRL, 32'h0000_0004, 32'h0000_0004);
        check(cmd_o.boost_start, 1'h0);
        check(cmd_o.eq_start, 1'h0);
        $display("thresholds test done");
    endtask : t_thr

    task automatic t_test();
        press(SEC / 2);
        rdm(`ADR_TEST, 32'h0000_0003, 32'h0000_0001);
        // each pass starts the test and cancels it a different way
        for (int k = 0; k < 3; k++) begin
            press(SEC + 4);
            rdm(`ADR_TEST, 32'h0000_0003, 32'h0000_0002);
            check(cmd_o.off, 1'h1);
            check(cmd_o.footer, `FOOT_TEST);
            rdm(`ADR_CTRL, 32'h0000_0001, 32'h0000_0000);
            case (k)
                0: wb(1'h1, `ADR_PRE, 32'h0000_0005);
                1: begin
                    ddp_block_i <= 1'h1;
                    repeat (3) @(posedge clk_i);
                    ddp_block_i <= 1'h0;
                end
                default: wb(1'h1, `ADR_CTRL, 32'h0000_0021);
            endcase
            rdm(`ADR_TEST, 32'h0000_0006, 32'h0000_0004);
        end
        $display("capacity test done");
    endtask : t_test

    task automatic t_cycle();
        int n;
        meas_i.cell_mv <= `CV_MV;
        meas_i.sum_ma  <= 16'h01F4;
        wb(1'h1, `ADR_BDUR, 32'h0000_0002);
        wb(1'h1, `ADR_CTRL, 32'h0000_0023);
        wb(1'h1, `ADR_CAP, 32'h0000_0032);
        rdm(`ADR_STAT, 32'h0000_0004, 32'h0000_0004);
        to_final();
        check(cmd_o.ilimit_en, 1'h1);
        check(cmd_o.ilimit_ma, 24'h00_03E8);
        check(cmd_o.footer, `FOOT_FINAL);
        meas_i.cell_mv <= 12'h09EC;
        meas_i.sum_ma  <= 16'hFFFF;
        n = float_cnt;
        wait_phase(2'h0, 600);
        check(32'(float_cnt), 32'(n + 1));
        // a later boost inside the period must not restart the cycle
        boost();
        rdm(`ADR_STAT, 32'h0000_0007, 32'h0000_0000);
        tick();
        rdm(`ADR_STAT, 32'h0000_0004, 32'h0000_0004);
        $display("full cycle done");
    endtask : t_cycle

    task automatic t_abort();
        int n;
        meas_i.cell_mv <= `CV_MV;
        meas_i.sum_ma  <= 16'h01F4;
        to_final();
        meas_i.cell_mv <= 12'h09C4;
        wait_phase(2'h1, 130);
        wait_phase(2'h2, 4);
        wait_phase(2'h3, 56);
        meas_i.cell_mv <= `TRIP_MV;
        wait_phase(2'h0, 2);
        rdm(`ADR_CTRL, 32'h0000_0001, 32'h0000_0000);
        check(cmd_o.off, 1'h1);
        // heavy current keeps the voltage phase until the capacity cap
        wb(1'h1, `ADR_CTRL, 32'h0000_0023);
        tick();
        meas_i.cell_mv <= `CV_MV;
        meas_i.sum_ma  <= 16'hFFFF;
        n = float_cnt;
        boost();
        wait_phase(2'h1, 2);
        wait_phase(2'h2, 4);
        wait_phase(2'h0, 1150);
        check(32'(float_cnt), 32'(n + 1));
        tick();
        boost();
        wait_phase(2'h1, 2);
        wb(1'h1, `ADR_CTRL, 32'h0000_0022);
        wait_phase(2'h0, 1);
        $display("abort test done");
    endtask : t_abort

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // main sequence after a two-cycle reset
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        t_regs();
        t_thr();
        t_test();
        t_cycle();
        t_abort();
        tally_and_finish();
    end
    // watchdog sized well above the roughly 40k cycles the tests need
    initial begin
        repeat (70000) @(posedge clk_i);
        num_errors++;
        tally_and_finish();
    end
endmodule : overcharge_seq_tb

/* design/overcharge_map.svh */
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef OVERCHARGE_MAP_SVH
`define OVERCHARGE_MAP_SVH
// register byte offsets
`define ADR_CTRL     8'h00
`define ADR_CAP      8'h04
`define ADR_PRE      8'h08
`define ADR_BDUR     8'h0C
`define ADR_THR      8'h10
`define ADR_STAT     8'h14
`define ADR_IREF     8'h18
`define ADR_TEST     8'h1C
// control register fields
`define CTRL_ON      0
`define CTRL_MODE    1
`define CTRL_SOC     2
`define CTRL_TYPE    4:3
`define CTRL_PER     7:5
`define CTRL_RST     32'h0000_0020
`define TYPE_LEAD    2'h0
`define TYPE_GEL     2'h1
// test register fields
`define TEST_DLG     0
`define TEST_ACT     1
`define TEST_CAN     2
// footer letters
`define FOOT_TEST    8'h43
`define FOOT_FINAL   8'h49
`define FOOT_NONE    8'h20
// timing
`define CLK_NS       5
`define SEC_NS       1000000000
`define HOLD_S       1
`define CV_LOW_S     50
`define FINAL_LOW_S  120
// electrical figures, mV per cell and Ah
`define CV_MV        12'h960
`define WIN_LO_MV    12'h9E2
`define WIN_HI_MV    12'h9F6
`define TRIP_MV      12'hA28
`define MIN_AH       16'h0032
`define REF_HOURS    50
`define MA_PER_A     1000
`define MAS_AH_PCT   36000
`define CV_PCT       7'h28
`define FINAL_PCT    7'h14
`endif

/* design/overcharge_pkg.sv */
// types shared by the overcharge sequencer and its users
package overcharge_pkg;
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_BOOST,
        PH_CV,
        PH_FINAL
    } phase_t;
    // measurements from the converter logic, same clock
    typedef struct packed {
        logic [15:0] bat_mv;
        logic [11:0] cell_mv;
        logic [6:0]  soc_pct;
        logic [15:0] sum_ma;
    } meas_t;
    // commands to the power stage and display
    typedef struct packed {
        logic        off;
        logic        boost_volt;
        logic        cv_volt;
        logic        ilimit_en;
        logic [23:0] ilimit_ma;
        logic [7:0]  footer;
        logic        float_req;
        logic        boost_start;
        logic        eq_start;
    } cmd_t;
endpackage : overcharge_pkg

/* design/overcharge_seq.sv */
// staged overcharge sequencer with capacity test control
`timescale 1ns/100ps
`include "overcharge_map.svh"
module overcharge_seq #(
    parameter int SEC_CYCLES = `SEC_NS / `CLK_NS
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic                 wb_we_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 confirm_btn_i,
    input  wire logic                 ddp_block_i,
    input  wire logic                 boost_done_i,
    input  wire logic                 month_tick_i,
    input  wire overcharge_pkg::meas_t meas_i,
    output overcharge_pkg::cmd_t      cmd_o
);
    import overcharge_pkg::*;

    localparam int HOLD_CYC = SEC_CYCLES * `HOLD_S;

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wr,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = wr[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // capacity limit in mA*s for a share of the nominal capacity
    function automatic logic [39:0] cap_lim(input logic [15:0] ah,
                                            input logic [6:0]  pct);
        return 40'(ah) * 40'(`MAS_AH_PCT) * 40'(pct);
    endfunction : cap_lim

    // bus and test state
    logic [31:0] ctrl_reg, ctrl_next;
    logic [15:0] cap_reg, cap_next;
    logic [31:0] pre_reg, pre_next;
    logic [15:0] bdur_reg, bdur_next;
    logic [31:0] thr_reg, thr_next;
    logic        dlg_reg, dlg_next;
    logic        tact_reg, tact_next;
    logic        tcan_reg, tcan_next;
    logic        ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic        btn_s1_reg, btn_s2_reg;
    logic [27:0] hold_reg, hold_next;
    // sequencer state
    phase_t      ph_reg, ph_next;
    logic        due_reg, due_next;
    logic        ok_d_reg;
    logic [2:0]  mon_reg, mon_next;
    logic [27:0] tick_reg, tick_next;
    logic [15:0] sec_reg, sec_next;
    logic [7:0]  low_reg, low_next;
    logic [39:0] acc_reg, acc_next;
    logic        cnt_on_reg, cnt_on_next;
    cmd_t        cmd_reg, cmd_next;
    logic        trip;
    logic        mode_ok;
    logic        type_ok;
    logic        tick;
    logic [23:0] iref;
    logic        wr_req;

    assign wr_req  = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg; // on ack edge
    assign tick    = (tick_reg == 28'(SEC_CYCLES - 1));
    assign type_ok = (ctrl_reg[`CTRL_TYPE] == `TYPE_LEAD) |
                     (ctrl_reg[`CTRL_TYPE] == `TYPE_GEL);
    assign mode_ok = ctrl_reg[`CTRL_MODE] & type_ok & (cap_reg >= `MIN_AH);
    assign iref    = 24'(32'(cap_reg) * `MA_PER_A / `REF_HOURS);

    // register file, button hold and capacity test control
    always_comb begin
        logic [31:0] wv;
        logic        start;
        wv        = 32'h0000_0000;
        start     = 1'b0;
        ctrl_next = ctrl_reg;
        cap_next  = cap_reg;
        pre_next  = pre_reg;
        bdur_next = bdur_reg;
        thr_next  = thr_reg;
        dlg_next  = dlg_reg;
        tact_next = tact_reg;
        tcan_next = tcan_reg;
        ack_next  = wb_cyc_i & wb_stb_i & ~ack_reg;
        dat_next  = 32'h0000_0000;
        // only the settled button level is timed
        hold_next = btn_s2_reg ? hold_reg + 28'h000_0001 : 28'h000_0000;
        if (wr_req) begin
            case (wb_adr_i)
                `ADR_CTRL: begin
                    wv        = merge(ctrl_reg, wb_dat_i, wb_sel_i);
                    ctrl_next = wv;
                    if (tact_reg && wv[`CTRL_ON] != ctrl_reg[`CTRL_ON]) begin
                        tact_next = 1'b0;
                        tcan_next = 1'b1;
                    end
                end
                `ADR_CAP: begin
                    wv       = merge({16'h0000, cap_reg}, wb_dat_i, wb_sel_i);
                    cap_next = wv[15:0];
                end
                `ADR_PRE: begin
                    wv       = merge(pre_reg, wb_dat_i, wb_sel_i);
                    pre_next = wv;
                    if (tact_reg && wv != pre_reg) begin
                        tact_next = 1'b0;
                        tcan_next = 1'b1;
                    end
                end
                `ADR_BDUR: begin
                    wv = merge({16'h0000, bdur_reg}, wb_dat_i, wb_sel_i);
                    bdur_next = wv[15:0];
                end
                `ADR_THR:  thr_next = merge(thr_reg, wb_dat_i, wb_sel_i);
                `ADR_TEST: begin
                    if (wb_sel_i[0]) begin
                        dlg_next = wb_dat_i[`TEST_DLG];
                    end
                end
                default: ;
            endcase
        end
        // blocked discharge ends test with no result
        if (tact_reg && ddp_block_i) begin
            tact_next = 1'b0;
            tcan_next = 1'b1;
        end
        // one second hold in the open dialogue
        start = dlg_reg & type_ok & ~tact_reg &
                (hold_reg == 28'(HOLD_CYC - 1));
        if (start) begin
            dlg_next  = 1'b0;
            tact_next = 1'b1;
            tcan_next = 1'b0;
        end
        // test start and overvoltage trip force off
        if (start || trip) begin
            ctrl_next[`CTRL_ON] = 1'b0;
        end
        if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg) begin
            case (wb_adr_i)
                `ADR_CTRL: dat_next = ctrl_reg;
                `ADR_CAP:  dat_next = {16'h0000, cap_reg};
                `ADR_PRE:  dat_next = pre_reg;
                `ADR_BDUR: dat_next = {16'h0000, bdur_reg};
                `ADR_THR:  dat_next = thr_reg;
                `ADR_STAT: dat_next = {20'h0_0000, low_reg, cnt_on_reg,
                                       due_reg, ph_reg};
                `ADR_IREF: dat_next = {8'h00, iref};
                `ADR_TEST: dat_next = {29'h0000_0000, tcan_reg, tact_reg,
                                       dlg_reg};
                default:   dat_next = 32'h0000_0000;
            endcase
        end
    end

    // registers of the bus and test group; ce_i low freezes them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg   <= `CTRL_RST;
            cap_reg    <= 16'h0000;
            pre_reg    <= 32'h0000_0000;
            bdur_reg   <= 16'h0000;
            thr_reg    <= 32'h0000_0000;
            dlg_reg    <= 1'b0;
            tact_reg   <= 1'b0;
            tcan_reg   <= 1'b0;
            ack_reg    <= 1'b0;
            dat_reg    <= 32'h0000_0000;
            btn_s1_reg <= 1'b0;
            btn_s2_reg <= 1'b0;
            hold_reg   <= 28'h000_0000;
        end else if (ce_i) begin
            ctrl_reg   <= ctrl_next;
            cap_reg    <= cap_next;
            pre_reg    <= pre_next;
            bdur_reg   <= bdur_next;
            thr_reg    <= thr_next;
            dlg_reg    <= dlg_next;
            tact_reg   <= tact_next;
            tcan_reg   <= tcan_next;
            ack_reg    <= ack_next;
            dat_reg    <= dat_next;
            btn_s1_reg <= confirm_btn_i;
            btn_s2_reg <= btn_s1_reg;
            hold_reg   <= hold_next;
        end
    end

    // overcharge phases, schedule and capacity counting
    always_comb begin
        logic [39:0] acc_add;
        acc_add     = acc_reg + 40'(meas_i.sum_ma);
        ph_next     = ph_reg;
        due_next    = due_reg;
        mon_next    = mon_reg;
        sec_next    = sec_reg;
        low_next    = low_reg;
        acc_next    = acc_reg;
        cnt_on_next = cnt_on_reg;
        tick_next   = tick ? 28'h000_0000 : tick_reg + 28'h000_0001;
        trip        = 1'b0;
        cmd_next    = cmd_reg;
        cmd_next.float_req = 1'b0;
        if (!mode_ok) begin
            due_next = 1'b0;
        end else if (!ok_d_reg) begin
            due_next = 1'b1;
            mon_next = 3'h0;
        end else if (month_tick_i && !due_reg) begin
            mon_next = mon_reg + 3'h1;
            if (mon_reg + 3'h1 >= ctrl_reg[`CTRL_PER]) begin
                due_next = 1'b1;
                mon_next = 3'h0;
            end
        end
        case (ph_reg)
            PH_IDLE: begin
                // only a boost completion while due starts it
                if (boost_done_i && due_reg && mode_ok &&
                    ctrl_reg[`CTRL_ON]) begin
                    ph_next  = PH_BOOST;
                    due_next = 1'b0;
                    mon_next = 3'h0;
                    sec_next = 16'h0000;
                end
            end
            PH_BOOST: begin
                // boost settings for the set duration
                if (tick) begin
                    sec_next = sec_reg + 16'h0001;
                end
                if (sec_reg >= bdur_reg) begin
                    ph_next  = PH_CV;
                    acc_next = 40'h00_0000_0000;
                    low_next = 8'h00;
                end
            end
            PH_CV: begin
                if (tick) begin
                    if (meas_i.cell_mv >= `CV_MV) begin
                        acc_next = acc_add;
                    end
                    if (24'(meas_i.sum_ma) < iref) begin
                        low_next = low_reg + 8'h01;
                    end else begin
                        low_next = 8'h00;
                    end
                end
                // too much charge taken, go float
                if (acc_reg > cap_lim(cap_reg, `CV_PCT)) begin
                    ph_next            = PH_IDLE;
                    cmd_next.float_req = 1'b1;
                end else if (low_reg >= 8'(`CV_LOW_S)) begin
                    ph_next     = PH_FINAL;
                    acc_next    = 40'h00_0000_0000;
                    cnt_on_next = 1'b0;
                    low_next    = 8'h00;
                end
            end
            PH_FINAL: begin
                if (meas_i.cell_mv >= `TRIP_MV) begin
                    trip    = 1'b1;
                    ph_next = PH_IDLE;
                end else if (acc_reg >= cap_lim(cap_reg, `FINAL_PCT)) begin
                    ph_next            = PH_IDLE;
                    cmd_next.float_req = 1'b1;
                end else if (low_reg > 8'(`FINAL_LOW_S)) begin
                    ph_next  = PH_BOOST;
                    sec_next = 16'h0000;
                end else if (tick) begin
                    if (meas_i.cell_mv >= `WIN_LO_MV &&
                        meas_i.cell_mv <= `WIN_HI_MV) begin
                        cnt_on_next = 1'b1;
                    end
                    if (cnt_on_reg) begin
                        acc_next = acc_add;
                    end
                    if (meas_i.cell_mv <= `WIN_LO_MV) begin
                        low_next = low_reg + 8'h01;
                    end else begin
                        low_next = 8'h00;
                    end
                end
            end
            default: ph_next = PH_IDLE;
        endcase
        if (!ctrl_reg[`CTRL_ON] && ph_reg != PH_IDLE) begin
            ph_next = PH_IDLE;
        end
        cmd_next.off        = ~ctrl_reg[`CTRL_ON];
        cmd_next.boost_volt = (ph_reg == PH_BOOST);
        cmd_next.cv_volt    = (ph_reg == PH_CV);
        // limit applies to own power stage only
        cmd_next.ilimit_en  = (ph_reg == PH_FINAL);
        cmd_next.ilimit_ma  = iref;
        // final phase letter, test letter first
        cmd_next.footer     = tact_reg ? `FOOT_TEST :
                              (ph_reg == PH_FINAL) ? `FOOT_FINAL :
                              `FOOT_NONE;
        if (ctrl_reg[`CTRL_SOC]) begin
            cmd_next.boost_start = 16'(meas_i.soc_pct) <= thr_reg[15:0];
            cmd_next.eq_start    = 16'(meas_i.soc_pct) <= thr_reg[31:16];
        end else begin
            cmd_next.boost_start = meas_i.bat_mv <= thr_reg[15:0];
            cmd_next.eq_start    = meas_i.bat_mv <= thr_reg[31:16];
        end
    end

    // registers of the sequencer group
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_reg     <= PH_IDLE;
            due_reg    <= 1'b0;
            ok_d_reg   <= 1'b0;
            mon_reg    <= 3'h0;
            tick_reg   <= 28'h000_0000;
            sec_reg    <= 16'h0000;
            low_reg    <= 8'h00;
            acc_reg    <= 40'h00_0000_0000;
            cnt_on_reg <= 1'b0;
            cmd_reg    <= '0;
        end else if (ce_i) begin
            ph_reg     <= ph_next;
            due_reg    <= due_next;
            ok_d_reg   <= mode_ok;
            mon_reg    <= mon_next;
            tick_reg   <= tick_next;
            sec_reg    <= sec_next;
            low_reg    <= low_next;
            acc_reg    <= acc_next;
            cnt_on_reg <= cnt_on_next;
            cmd_reg    <= cmd_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign cmd_o    = cmd_reg;
endmodule : overcharge_seq
